/* rtl/flash_ctrl_defs.svh */
`ifndef FLASH_CTRL_DEFS_SVH
`define FLASH_CTRL_DEFS_SVH

// register byte offsets
`define OFS_READY         12'h400
`define OFS_CONFIG        12'h504
`define OFS_PAGE_ERASE    12'h508
`define OFS_FULL_ERASE    12'h50C
`define OFS_PAGE_ALIAS_B  12'h510
`define OFS_USER_ERASE    12'h514
`define OFS_PARTIAL_START 12'h518
`define OFS_PARTIAL_DUR   12'h51C
`define OFS_ERASE_CYCLES  12'h520

// reset values
`define RST_READY         32'h00000001
`define RST_CONFIG        32'h00000000
`define RST_START         32'h00000000
`define RST_PARTIAL_DUR   32'h0000000A

// field positions and encodings
`define MODE_MSB          1
`define MODE_LSB          0
`define CMD_BIT           0
`define MODE_READ         2'h0
`define MODE_WRITE        2'h1
`define MODE_ERASE        2'h2
`define SIZE_WORD         2'h2
`define PAGE_LSB          12

// timing: figures as printed, cycle counts derived from the clock rate
`define CLK_MHZ           250
`define T_WRITE_US        41
`define PAGE_ERASE_TIME_MS    85
`define FULL_ERASE_TIME_MS     169
`define CYC_PER_MS        (`CLK_MHZ * 1000)
`define WRITE_CYC         (`T_WRITE_US * `CLK_MHZ)
`define PAGE_ERASE_START_CYC     (`PAGE_ERASE_TIME_MS * `CYC_PER_MS)
`define FULL_ERASE_START_CYC      (`FULL_ERASE_TIME_MS * `CYC_PER_MS)

`endif

/* rtl/flash_ctrl_pkg.sv */
package flash_ctrl_pkg;

   // operation the controller is driving into the flash array
   typedef enum logic [2:0] {
      OP_IDLE,
      OP_PROGRAM,
      OP_ERASE_PAGE,
      OP_ERASE_PARTIAL,
      OP_ERASE_USER,
      OP_ERASE_ALL
   } op_e;

   typedef logic [1:0] mode_t;

endpackage

/* rtl/op_timer.sv */
`timescale 1ns/100ps
module op_timer #(
   parameter int W = 40
) (
   input  logic         mclk,
   input  logic         sys_rst,
   input  logic         load,
   input  logic [W-1:0] load_val,
   output logic         done
);

   logic [W-1:0] cnt;

   // down counter, a zero load still lasts one cycle
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt <= '0;
      end else if (load) begin
         cnt <= (load_val == '0) ? W'(1) : load_val;
      end else if (cnt != '0) begin
         cnt <= cnt - W'(1);
      end
   end

   // last cycle of the loaded interval
   assign done = (cnt == W'(1)) && !load;

endmodule

/* rtl/flash_program_erase_ctrl.sv */
// Overview of operation
// - access mode 0 read only, 1 write, 2 erase; resets to read only
// - write mode programs whole 32-bit words at aligned addresses only
// - programming only clears bits; ones keep bits unchanged
// - byte or halfword program access raises hard fault, no write
// - word program lasts at most 41 us, processor stalled throughout
// - erase mode: page address to page erase register erases page
// - page erase sets page to ones within 85 ms
// - during erase processor stalls only when fetching from flash
// - user area programmed like flash, takes effect after reset
// - erase mode: writing 1 erases user area; writing 0 does nothing
// - erase mode: writing 1 erases flash and user area, not factory
// - full chip erase completes within 169 ms
// - partial erase runs configured milliseconds, duration resets to ten
// - partial erase touches code area only, never user area
// - partial time accumulates per page; at page time one cycle counts
// - page contents undefined while accumulated time below page time
// - each partial erase lasts duration times at most 1.05
// - ready reads 0 while busy, 1 when idle; resets to 1
// - alias at 0x510 acts like page erase register at 0x508
// - pages are 4 kB; erase works on one page at a time
`timescale 1ns/100ps
`include "flash_ctrl_defs.svh"
module flash_program_erase_ctrl #(
   parameter logic [39:0] WRITE_CYCLES      = 40'(`WRITE_CYC),
   parameter logic [39:0] ERASE_PAGE_CYCLES = 40'(`PAGE_ERASE_START_CYC),
   parameter logic [39:0] ERASE_ALL_CYCLES  = 40'(`FULL_ERASE_START_CYC),
   parameter logic [39:0] CYCLES_PER_MS     = 40'(`CYC_PER_MS),
   parameter logic [31:0] PAGE_ERASE_MS     = 32'(`PAGE_ERASE_TIME_MS),
   parameter int          PAGE_IDX_W        = 6,
   parameter int          ACC_W             = 8
) (
   input  logic                 mclk,
   input  logic                 sys_rst,
   input  logic [11:0]          address,
   input  logic                 read,
   input  logic                 write,
   input  logic [31:0]          writedata,
   input  logic [3:0]           byteenable,
   output logic [31:0]          readdata,
   output logic                 waitrequest,
   input  logic                 prog_req,
   input  logic [31:0]          prog_addr,
   input  logic [31:0]          prog_data,
   input  logic [1:0]           prog_size,
   input  logic                 prog_user,
   input  logic                 cpu_fetch_flash,
   output logic                 hard_fault,
   output logic                 cpu_stall,
   output flash_ctrl_pkg::op_e  flash_op,
   output logic [31:0]          flash_addr,
   output logic [31:0]          flash_wdata,
   output logic                 flash_user,
   output logic                 flash_page_done
);
   import flash_ctrl_pkg::*;

   op_e                   op;
   op_e                   next_op;
   mode_t                 mode;
   logic [31:0]           page_reg;
   logic [31:0]           alias_b_reg;
   logic [31:0]           full_reg;
   logic [31:0]           user_reg;
   logic [31:0]           partial_reg;
   logic [31:0]           dur_reg;
   logic [31:0]           cycles_reg;
   logic [ACC_W-1:0]      acc [2**PAGE_IDX_W];
   logic [PAGE_IDX_W-1:0] pidx;
   logic [39:0]           load_val;
   logic [39:0]           op_age;
   logic [32:0]           acc_sum;
   logic                  wr_fire;
   logic                  erase_ok;
   logic                  go_page;
   logic                  go_full;
   logic                  go_user;
   logic                  go_partial;
   logic                  prog_bad;
   logic                  prog_go;
   logic                  timer_load;
   logic                  timer_done;

   // bus write takes effect at the edge where waitrequest is seen low
   assign wr_fire  = write && !waitrequest && (byteenable == 4'hF);
   // erase commands need erase mode and an idle controller
   assign erase_ok = (mode == `MODE_ERASE) && (op == OP_IDLE);

   // page erase through the main register and its one alias
   assign go_page    = wr_fire && erase_ok &&
                       (address == `OFS_PAGE_ERASE ||
                        address == `OFS_PAGE_ALIAS_B);
   assign go_full    = wr_fire && erase_ok &&
                       (address == `OFS_FULL_ERASE) &&
                       writedata[`CMD_BIT];
   assign go_user    = wr_fire && erase_ok &&
                       (address == `OFS_USER_ERASE) &&
                       writedata[`CMD_BIT];
   assign go_partial = wr_fire && erase_ok &&
                       (address == `OFS_PARTIAL_START);

   // only aligned whole words may be programmed
   assign prog_bad = prog_req && ((prog_size != `SIZE_WORD) ||
                     (prog_addr[1:0] != 2'h0));
   assign prog_go  = prog_req && !prog_bad &&
                     (mode == `MODE_WRITE) && (op == OP_IDLE);

   // page accumulator plus this partial duration, in milliseconds
   assign acc_sum = 33'(acc[pidx]) + 33'(dur_reg);

   // next operation and its duration
   always_comb begin
      next_op  = op;
      load_val = 40'h0;
      if (op == OP_IDLE) begin
         if (prog_go) begin
            next_op  = OP_PROGRAM;
            load_val = WRITE_CYCLES;
         end else if (go_page) begin
            next_op  = OP_ERASE_PAGE;
            load_val = ERASE_PAGE_CYCLES;
         end else if (go_user) begin
            next_op  = OP_ERASE_USER;
            load_val = ERASE_PAGE_CYCLES;
         end else if (go_full) begin
            next_op  = OP_ERASE_ALL;
            load_val = ERASE_ALL_CYCLES;
         end else if (go_partial) begin
            next_op  = OP_ERASE_PARTIAL;
            // accuracy factor taken as exactly one
            load_val = 40'(dur_reg * CYCLES_PER_MS);
         end
      end else if (timer_done) begin
         next_op = OP_IDLE;
      end
   end

   assign timer_load = (op == OP_IDLE) && (next_op != OP_IDLE);

   op_timer #(
      .W (40)
   ) u_timer (
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .load     (timer_load),
      .load_val (load_val),
      .done     (timer_done)
   );

   // operation state; flash_op mirrors it to the array
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         op <= OP_IDLE;
      end else begin
         case (next_op)
            OP_IDLE,
            OP_PROGRAM,
            OP_ERASE_PAGE,
            OP_ERASE_PARTIAL,
            OP_ERASE_USER,
            OP_ERASE_ALL: op <= next_op;
            default:      op <= OP_IDLE;
         endcase
      end
   end

   assign flash_op = op;

   // array address, data and target latched at operation start
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         flash_addr  <= 32'h0;
         flash_wdata <= 32'hFFFFFFFF;
         flash_user  <= 1'b0;
         pidx        <= '0;
      end else if (timer_load) begin
         if (prog_go) begin
            // array only clears bits; ones leave cells untouched
            flash_addr  <= prog_addr;
            flash_wdata <= prog_data;
            // user area words share the program path and count limit
            flash_user  <= prog_user;
         end else begin
            // erase targets one 4 kB page, low bits dropped
            flash_addr  <= {writedata[31:`PAGE_LSB],
                            {`PAGE_LSB{1'b0}}};
            flash_wdata <= 32'hFFFFFFFF;
            // full erase covers user area; factory area never driven
            flash_user  <= go_user || go_full;
            pidx        <= writedata[`PAGE_LSB +: PAGE_IDX_W];
         end
      end
   end

   // per page partial erase bookkeeping
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < 2**PAGE_IDX_W; i++) begin
            acc[i] <= '0;
         end
         cycles_reg      <= 32'h0;
         flash_page_done <= 1'b0;
      end else begin
         flash_page_done <= 1'b0;
         if (timer_done) begin
            case (op)
               OP_ERASE_PARTIAL: begin
                  // below page time the page holds undefined data
                  if (acc_sum >= 33'(PAGE_ERASE_MS)) begin
                     acc[pidx]       <= '0;
                     cycles_reg      <= cycles_reg + 32'h1;
                     flash_page_done <= 1'b1;
                  end else begin
                     acc[pidx] <= acc_sum[ACC_W-1:0];
                  end
               end
               OP_ERASE_PAGE: begin
                  acc[pidx]       <= '0;
                  flash_page_done <= 1'b1;
               end
               OP_ERASE_ALL: begin
                  for (int i = 0; i < 2**PAGE_IDX_W; i++) begin
                     acc[i] <= '0;
                  end
               end
               default: ;
            endcase
         end
      end
   end

   // processor stall: always for program, fetches only for erases
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cpu_stall <= 1'b0;
      end else begin
         cpu_stall <= (next_op == OP_PROGRAM) ||
                      ((next_op != OP_IDLE) && cpu_fetch_flash);
      end
   end

   // hard fault pulse on a narrow or misaligned program access
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         hard_fault <= 1'b0;
      end else begin
         hard_fault <= prog_bad;
      end
   end

   // software registers
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         mode        <= mode_t'(`RST_CONFIG);
         page_reg    <= `RST_START;
         alias_b_reg <= `RST_START;
         full_reg    <= `RST_START;
         user_reg    <= `RST_START;
         partial_reg <= `RST_START;
         dur_reg     <= `RST_PARTIAL_DUR;
      end else if (wr_fire) begin
         case (address)
            // both modes at once is left to software to avoid
            `OFS_CONFIG:        mode <= writedata[`MODE_MSB:`MODE_LSB];
            `OFS_PAGE_ERASE:    page_reg    <= writedata;
            `OFS_PAGE_ALIAS_B:  alias_b_reg <= writedata;
            `OFS_FULL_ERASE:    full_reg    <= writedata;
            `OFS_USER_ERASE:    user_reg    <= writedata;
            `OFS_PARTIAL_START: partial_reg <= writedata;
            `OFS_PARTIAL_DUR:   dur_reg     <= writedata;
            default: ;
         endcase
      end
   end

   // one wait cycle per request, then the answer
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= !((read || write) && waitrequest);
      end
   end

   // read data captured during the wait cycle
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         readdata <= 32'h0;
      end else if (read && waitrequest) begin
         case (address)
            `OFS_READY:
               readdata <= {31'h0, op == OP_IDLE};
            `OFS_CONFIG:        readdata <= {30'h0, mode};
            `OFS_PAGE_ERASE:    readdata <= page_reg;
            `OFS_PAGE_ALIAS_B:  readdata <= alias_b_reg;
            `OFS_FULL_ERASE:    readdata <= full_reg;
            `OFS_USER_ERASE:    readdata <= user_reg;
            `OFS_PARTIAL_START: readdata <= partial_reg;
            `OFS_PARTIAL_DUR:   readdata <= dur_reg;
            `OFS_ERASE_CYCLES:  readdata <= cycles_reg;
            default:            readdata <= 32'h0;
         endcase
      end
   end

   // age of the current operation, read by assertions only
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         op_age <= 40'h0;
      end else if (timer_load) begin
         op_age <= 40'h1;
      end else if (op != OP_IDLE) begin
         op_age <= op_age + 40'h1;
      end else begin
         op_age <= 40'h0;
      end
   end

   sequence s_prog_go;
      prog_req && !prog_bad && (mode == `MODE_WRITE) && (op == OP_IDLE);
   endsequence

   sequence s_partial_go;
      wr_fire && (address == `OFS_PARTIAL_START) &&
      (mode == `MODE_ERASE) && (op == OP_IDLE);
   endsequence

   property p_ready_read;
      @(posedge mclk) disable iff (sys_rst)
      (read && waitrequest && address == `OFS_READY) |=>
         (readdata == {31'h0, $past(op) == OP_IDLE});
   endproperty
   a_ready_read: assert property (p_ready_read)
      else $error("ready flag does not match controller state");

   property p_narrow_fault;
      @(posedge mclk) disable iff (sys_rst)
      (prog_req && prog_size != `SIZE_WORD) |=>
         hard_fault && (flash_op != OP_PROGRAM || $past(op) == OP_PROGRAM);
   endproperty
   a_narrow_fault: assert property (p_narrow_fault)
      else $error("narrow program access did not fault");

   property p_prog_aligned;
      @(posedge mclk) disable iff (sys_rst)
      s_prog_go |=> (flash_op == OP_PROGRAM) && (flash_addr[1:0] == 2'h0)
         && cpu_stall;
   endproperty
   a_prog_aligned: assert property (p_prog_aligned)
      else $error("program start missing or misaligned");

   property p_prog_time;
      @(posedge mclk) disable iff (sys_rst)
      (op == OP_PROGRAM && op_age == WRITE_CYCLES) |=>
         (op == OP_IDLE) && !$past(op_age > WRITE_CYCLES);
   endproperty
   a_prog_time: assert property (p_prog_time)
      else $error("word program did not end on time");

   property p_prog_stall;
      @(posedge mclk) disable iff (sys_rst)
      (flash_op == OP_PROGRAM) |-> cpu_stall;
   endproperty
   a_prog_stall: assert property (p_prog_stall)
      else $error("processor not stalled during program");

   property p_erase_no_stall;
      @(posedge mclk) disable iff (sys_rst)
      (!cpu_fetch_flash && op != OP_PROGRAM && !prog_go) |=> !cpu_stall;
   endproperty
   a_erase_no_stall: assert property (p_erase_no_stall)
      else $error("processor stalled without a flash fetch");

   property p_erase_gated;
      @(posedge mclk) disable iff (sys_rst)
      (wr_fire && mode != `MODE_ERASE && op == OP_IDLE &&
       address >= `OFS_PAGE_ERASE && address <= `OFS_PARTIAL_START)
         |=> (flash_op == OP_IDLE || flash_op == OP_PROGRAM);
   endproperty
   a_erase_gated: assert property (p_erase_gated)
      else $error("erase started without erase mode");

   property p_user_zero;
      @(posedge mclk) disable iff (sys_rst)
      (wr_fire && address == `OFS_USER_ERASE && !writedata[`CMD_BIT] &&
       op == OP_IDLE) |=> (flash_op == OP_IDLE || flash_op == OP_PROGRAM);
   endproperty
   a_user_zero: assert property (p_user_zero)
      else $error("writing zero started a user area erase");

   property p_partial_code_only;
      @(posedge mclk) disable iff (sys_rst)
      s_partial_go |=> (flash_op == OP_ERASE_PARTIAL) && !flash_user
         ##1 (flash_op == OP_ERASE_PARTIAL || flash_op == OP_IDLE);
   endproperty
   a_partial_code_only: assert property (p_partial_code_only)
      else $error("partial erase not started on code area");

endmodule

/* verif/flash_array_model.sv */
`timescale 1ns/100ps
module flash_array_model (
   input logic                mclk,
   input flash_ctrl_pkg::op_e flash_op,
   input logic [31:0]         flash_addr,
   input logic [31:0]         flash_wdata,
   input logic                flash_user,
   input logic                flash_page_done
);
   import flash_ctrl_pkg::*;
   logic [31:0] mem  [int];
   logic [31:0] umem [int];
   op_e         prev_op = OP_IDLE;

   // absent word reads as erased
   function automatic logic [31:0] peek(input logic user, input int a);
      if (user)
         return umem.exists(a) ? umem[a] : 32'hFFFFFFFF;
      return mem.exists(a) ? mem[a] : 32'hFFFFFFFF;
   endfunction

   // wipe one whole page of the code area only
   task automatic wipe_page(input int a);
      int q[$];
      foreach (mem[k]) if ((k >> 12) == (a >> 12)) q.push_back(k);
      foreach (q[i]) mem.delete(q[i]);
   endtask

   // act on each operation start, pages on completion pulse
   always @(posedge mclk) begin
      prev_op <= flash_op;
      if (flash_op == OP_PROGRAM && prev_op != OP_PROGRAM) begin
         if (flash_user)
            umem[int'(flash_addr)] = peek(1, int'(flash_addr)) & flash_wdata;
         else
            mem[int'(flash_addr)] = peek(0, int'(flash_addr)) & flash_wdata;
      end
      if (flash_op == OP_ERASE_USER && prev_op != OP_ERASE_USER)
         umem.delete();
      if (flash_op == OP_ERASE_ALL && prev_op != OP_ERASE_ALL) begin
         mem.delete();
         umem.delete();
      end
      if (flash_page_done)
         wipe_page(int'(flash_addr));
   end
endmodule

/* verif/tb.sv */
`timescale 1ns/100ps
module tb;
   import flash_ctrl_pkg::*;
   logic        mclk = 0;
   logic        sys_rst = 1;
   logic [11:0] address = 12'h000;
   logic        read = 0;
   logic        write = 0;
   logic [31:0] writedata = 0;
   logic [3:0]  byteenable = 4'hF;
   logic [31:0] readdata, flash_addr, flash_wdata;
   logic        waitrequest, hard_fault, cpu_stall, flash_user;
   logic        flash_page_done;
   logic        prog_req = 0;
   logic [31:0] prog_addr = 0;
   logic [31:0] prog_data = 0;
   logic [1:0]  prog_size = 2'h2;
   logic        prog_user = 0;
   logic        cpu_fetch_flash = 0;
   op_e         flash_op;
   int          bad_count = 0, checked = 0, cycles = 0;
   int          run_len = 0, last_len = 0, starts = 0;
   int          dones = 0, faults = 0, stalls = 0;
   int          n0, d0, s0;
   logic [31:0] seed = 32'h0B0E4478;
   logic [31:0] rd, a, d1, d2, pa, c0;
   logic [11:0] ofs [9] = '{12'h400, 12'h504, 12'h508, 12'h50C, 12'h510,
                            12'h514, 12'h518, 12'h51C, 12'h600};
   logic [31:0] rst [9] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h0,
                            32'h0, 32'h0, 32'hA, 32'h0};

   always #2 mclk = ~mclk;

   flash_program_erase_ctrl #(
      .WRITE_CYCLES(40'd20), .ERASE_PAGE_CYCLES(40'd50),
      .ERASE_ALL_CYCLES(40'd100), .CYCLES_PER_MS(40'd5)
   ) u_flash_program_erase_ctrl (
      .mclk(mclk), .sys_rst(sys_rst), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest),
      .prog_req(prog_req), .prog_addr(prog_addr), .prog_data(prog_data),
      .prog_size(prog_size), .prog_user(prog_user),
      .cpu_fetch_flash(cpu_fetch_flash), .hard_fault(hard_fault),
      .cpu_stall(cpu_stall), .flash_op(flash_op), .flash_addr(flash_addr),
      .flash_wdata(flash_wdata), .flash_user(flash_user),
      .flash_page_done(flash_page_done)
   );

   flash_array_model u_flash_array_model (
      .mclk(mclk), .flash_op(flash_op), .flash_addr(flash_addr),
      .flash_wdata(flash_wdata), .flash_user(flash_user),
      .flash_page_done(flash_page_done)
   );

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic give_verdict;
      if (bad_count == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // operation lengths, starts, pulses, timeout
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         give_verdict;
      end
      if (flash_op !== OP_IDLE) begin
         run_len <= run_len + 1;
         if (run_len == 0)
            starts <= starts + 1;
      end else if (run_len != 0) begin
         last_len <= run_len;
         run_len <= 0;
      end
      dones <= dones + int'(flash_page_done);
      faults <= faults + int'(hard_fault);
      stalls <= stalls + int'(cpu_stall);
   end

   // one avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic rw, input logic [11:0] ad,
                      input logic [31:0] dat);
      @(posedge mclk);
      address <= ad;
      writedata <= dat;
      read <= !rw;
      write <= rw;
      do @(posedge mclk); while (waitrequest !== 1'b0);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] ad, input logic [31:0] dat);
      bus(1'b1, ad, dat);
   endtask

   task automatic rdc(input logic [11:0] ad, input logic [31:0] exp);
      bus(1'b0, ad, 32'h0);
      chk(rd, exp);
   endtask

   task automatic prog(input logic [31:0] ad, input logic [31:0] dat,
                       input logic [1:0] sz, input logic usr);
      @(posedge mclk);
      prog_req <= 1'b1;
      prog_addr <= ad;
      prog_data <= dat;
      prog_size <= sz;
      prog_user <= usr;
      @(posedge mclk);
      prog_req <= 1'b0;
   endtask

   task automatic idle;
      repeat (3) @(posedge mclk);
      while (flash_op !== OP_IDLE) @(posedge mclk);
      repeat (2) @(posedge mclk);
   endtask

   initial begin
      repeat (16) @(posedge mclk);
      sys_rst <= 1'b0;
      // reset values and an unmapped place
      foreach (ofs[i]) rdc(ofs[i], rst[i]);
      // partial byte enables leave a register untouched
      byteenable <= 4'h3;
      wr(12'h51C, 32'h5);
      byteenable <= 4'hF;
      rdc(12'h51C, 32'hA);
      for (int m = 0; m < 3; m++) begin
         wr(12'h504, 32'(m));
         rdc(12'h504, 32'(m));
      end
      // program one word twice at a random aligned place
      seed = lfsr(seed);
      a = {14'h0, seed[17:2], 2'h0};
      d1 = lfsr(seed);
      d2 = lfsr(d1);
      seed = d2;
      wr(12'h504, 32'h1);
      s0 = stalls;
      prog(a, d1, 2'h2, 1'b0);
      idle;
      chk(last_len, 20);
      chk(stalls - s0, 20);
      prog(a, d2, 2'h2, 1'b0);
      idle;
      chk(flash_addr, a);
      chk(u_flash_array_model.peek(0, a), d1 & d2);
      // rejected sizes and misalignment, then write disabled
      d0 = faults;
      n0 = starts;
      prog(a, d1, 2'h0, 1'b0);
      prog(a, d1, 2'h1, 1'b0);
      prog(a + 2, d1, 2'h2, 1'b0);
      repeat (3) @(posedge mclk);
      chk(faults - d0, 3);
      wr(12'h504, 32'h0);
      prog(a, d1, 2'h2, 1'b0);
      wr(12'h508, a);
      repeat (4) @(posedge mclk);
      chk(starts - n0, 0);
      // page erase through the register and its one alias
      wr(12'h504, 32'h2);
      foreach (ofs[i]) if (i == 2 || i == 4) begin
         pa = (i == 2) ? (a & 32'hFFFFF000) : {14'h0, seed[5:0], 12'h000};
         n0 = starts;
         d0 = dones;
         s0 = stalls;
         wr(ofs[i], pa);
         rdc(12'h400, 32'h0);
         wr(12'h50C, 32'h1);
         idle;
         chk(last_len, 50);
         chk(starts - n0, 1);
         chk(dones - d0, 1);
         chk(flash_addr, pa);
         chk(stalls - s0, 0);
         rdc(12'h400, 32'h1);
      end
      chk(u_flash_array_model.peek(0, a), 32'hFFFFFFFF);
      // user area programming and erasure
      wr(12'h504, 32'h1);
      prog(a, 32'h0, 2'h2, 1'b1);
      idle;
      chk({31'h0, flash_user}, 32'h1);
      chk(u_flash_array_model.peek(1, a), 32'h0);
      wr(12'h504, 32'h2);
      n0 = starts;
      wr(12'h514, 32'h0);
      repeat (4) @(posedge mclk);
      chk(starts - n0, 0);
      wr(12'h514, 32'h1);
      idle;
      chk(last_len, 50);
      chk(u_flash_array_model.peek(1, a), 32'hFFFFFFFF);
      // full erase while the processor fetches from flash
      wr(12'h504, 32'h1);
      prog(a, d1, 2'h2, 1'b0);
      idle;
      prog(a, d1, 2'h2, 1'b1);
      idle;
      wr(12'h504, 32'h2);
      cpu_fetch_flash <= 1'b1;
      s0 = stalls;
      wr(12'h50C, 32'h1);
      idle;
      cpu_fetch_flash <= 1'b0;
      chk(last_len, 100);
      chk(stalls - s0, 100);
      chk({31'h0, flash_user}, 32'h1);
      chk(u_flash_array_model.peek(0, a), 32'hFFFFFFFF);
      chk(u_flash_array_model.peek(1, a), 32'hFFFFFFFF);
      // five partial chunks of 17 ms make one 85 ms erase
      wr(12'h504, 32'h1);
      prog(a, d1, 2'h2, 1'b0);
      idle;
      wr(12'h504, 32'h2);
      wr(12'h51C, 32'd17);
      bus(1'b0, 12'h520, 32'h0);
      c0 = rd;
      d0 = dones;
      for (int i = 0; i < 5; i++) begin
         chk(dones - d0, 0);
         wr(12'h518, a & 32'hFFFFF000);
         idle;
         chk(last_len, 85);
         chk({31'h0, flash_user}, 32'h0);
      end
      chk(dones - d0, 1);
      chk(u_flash_array_model.peek(0, a), 32'hFFFFFFFF);
      rdc(12'h520, c0 + 1);
      // mid-run reset restores the register defaults
      sys_rst <= 1'b1;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      rdc(12'h504, 32'h0);
      rdc(12'h51C, 32'hA);
      rdc(12'h400, 32'h1);
      give_verdict;
   end
endmodule
